// >>> include/legacy_timer_pkg.sv
package legacy_timer_pkg;
    // register addresses on the special function register port
    localparam logic [7:0] ModeSelectAddr = 8'h89;
    localparam logic [7:0] FirstLowAddr = 8'h8a;
    localparam logic [7:0] SecondLowAddr = 8'h8b;
    localparam logic [7:0] FirstHighAddr = 8'h8c;
    localparam logic [7:0] SecondHighAddr = 8'h8d;
    localparam logic [7:0] ClockControlAddr = 8'h8e;
    // reset values
    localparam logic [7:0] ModeSelectReset = 8'h00;
    localparam logic [7:0] CountReset = 8'h00;
    localparam logic [7:0] ClockControlReset = 8'h00;
    // mode select field positions
    localparam int SecondGateBit = 7;
    localparam int SecondCounterBit = 6;
    localparam int SecondModeLsb = 4;
    localparam int FirstGateBit = 3;
    localparam int FirstCounterBit = 2;
    localparam int FirstModeLsb = 0;
    // clock control field positions and writable mask
    localparam int SecondClockBit = 4;
    localparam int FirstClockBit = 3;
    localparam int PrescaleLsb = 0;
    localparam logic [7:0] ClockControlMask = 8'h1b;
    // prescaler division ratios
    localparam logic [5:0] DivBy12 = 6'h0c;
    localparam logic [5:0] DivBy4 = 6'h04;
    localparam logic [5:0] DivBy48 = 6'h30;
    localparam logic [5:0] DivBy8 = 6'h08;
    // low byte bits that belong to the 13-bit count
    localparam logic [7:0] Low13Mask = 8'h1f;

    typedef enum logic [1:0] {
        Mode13Bit = 2'b00,
        Mode16Bit = 2'b01,
        Mode8Reload = 2'b10,
        ModeSplit = 2'b11
    } timer_mode_t;

    typedef enum logic [1:0] {
        Scale12 = 2'b00,
        Scale4 = 2'b01,
        Scale48 = 2'b10,
        ScaleExt8 = 2'b11
    } prescale_t;
endpackage

// >>> verilog/dual_legacy_counter_timer.sv
`timescale 1ns/100ps
// Contract
// - outside split mode, second timer runs when run bit set, and gate clear or second irq input high
// - first timer runs when run bit set, and gate clear or first irq input high
// - outside split mode, second counter-select picks selected clock or falling edges on second count pin
// - first counter-select picks selected clock or falling edges on first count pin
// - second mode field: 13-bit, 16-bit, 8-bit reload, or inactive
// - first mode field: 13-bit, 16-bit, 8-bit reload, or two 8-bit counters
// - second clock-select: prescaled or system clock, ignored when counting edges
// - first clock-select: prescaled or system clock, ignored when counting edges
// - prescale field divides sysclk by 12, 4, 48, or external clock by 8
// - clock control bits 7-5 and 2 read zero, writes discarded
// - first timer low and high bytes readable, writable, reset to zero
// - second timer low and high bytes readable, writable, reset to zero
// - 13-bit mode uses high byte and low bits 4-0, overflow sets flag
// - 8-bit reload: low byte overflows, sets flag, reloads from high byte
// - split mode high byte times under second run bit, sets second flag
// - overflow flags set by hardware, cleared by software or on vector
module dual_legacy_counter_timer
    import legacy_timer_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    // neighbouring timer control bits
    input wire logic firstRunBit,
    input wire logic secondRunBit,
    input wire logic firstOverflowClear,
    input wire logic secondOverflowClear,
    input wire logic firstVectorAck,
    input wire logic secondVectorAck,
    output logic firstOverflowFlag,
    output logic secondOverflowFlag,
    // pins
    input wire logic firstExtIrqInput,
    input wire logic secondExtIrqInput,
    input wire logic firstCountPin,
    input wire logic secondCountPin,
    input wire logic extClock
);
    logic [7:0] modeSelect_q;
    logic [7:0] clockControl_q;
    logic [7:0] firstLow_q, firstHigh_q, secondLow_q, secondHigh_q;
    logic [2:0] firstPin_q, secondPin_q, extClk_q;
    logic [1:0] irq0_q, irq1_q;
    logic [5:0] preCnt_q;
    logic prescaleTick;
    logic [5:0] divisor;
    logic extEdge, firstPinEdge, secondPinEdge;
    logic firstRun, secondRun, firstTick, secondTick, splitTick;
    logic firstOvf, secondOvf, splitOvf;
    timer_mode_t firstMode, secondMode;

    // next value of a count pair; returns {overflow, high, low}
    function automatic logic [16:0] step(input timer_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
        logic [8:0] l9;
        logic [16:0] r;
        l9 = {1'b0, lo} + 9'h001;
        r = {1'b0, hi, lo};
        unique case (m)
            Mode13Bit: begin
                if (lo[4:0] == 5'h1f) begin
                    r = {hi == 8'hff, hi + 8'h01, lo & ~Low13Mask};
                end else begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            Mode16Bit: r = {1'b0, hi, lo} + 17'h00001;
            Mode8Reload: r = l9[8] ? {1'b1, hi, hi} : {1'b0, hi, l9[7:0]};
            ModeSplit: r = {l9[8], hi, l9[7:0]};
        endcase
        return r;
    endfunction

    assign firstMode = timer_mode_t'(modeSelect_q[FirstModeLsb +: 2]);
    assign secondMode = timer_mode_t'(modeSelect_q[SecondModeLsb +: 2]);

    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            firstPin_q <= 3'h0;
            secondPin_q <= 3'h0;
            extClk_q <= 3'h0;
            irq0_q <= 2'h0;
            irq1_q <= 2'h0;
        end else begin
            firstPin_q <= {firstPin_q[1:0], firstCountPin};
            secondPin_q <= {secondPin_q[1:0], secondCountPin};
            extClk_q <= {extClk_q[1:0], extClock};
            irq0_q <= {irq0_q[0], firstExtIrqInput};
            irq1_q <= {irq1_q[0], secondExtIrqInput};
        end
    end

    assign firstPinEdge = firstPin_q[2] & ~firstPin_q[1];
    assign secondPinEdge = secondPin_q[2] & ~secondPin_q[1];
    assign extEdge = extClk_q[2] & ~extClk_q[1];

    // shared prescaler; external source counts its edges
    always_comb begin
        unique case (prescale_t'(clockControl_q[PrescaleLsb +: 2]))
            Scale12: divisor = DivBy12;
            Scale4: divisor = DivBy4;
            Scale48: divisor = DivBy48;
            ScaleExt8: divisor = DivBy8;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preCnt_q <= 6'h00;
        end else if (clockControl_q[1:0] != ScaleExt8 || extEdge) begin
            preCnt_q <= (preCnt_q >= divisor - 6'h01) ? 6'h00 : preCnt_q + 6'h01;
        end
    end
    assign prescaleTick = (preCnt_q >= divisor - 6'h01) && (clockControl_q[1:0] != ScaleExt8 || extEdge);

    // run qualification and increment sources
    assign firstRun = firstRunBit & (~modeSelect_q[FirstGateBit] | irq0_q[1]);
    assign secondRun = secondRunBit & (~modeSelect_q[SecondGateBit] | irq1_q[1]);
    assign firstTick = firstRun & (modeSelect_q[FirstCounterBit] ? firstPinEdge :
        (clockControl_q[FirstClockBit] | prescaleTick));
    // in split mode the second timer loses its run bit and edge input
    assign secondTick = (firstMode == ModeSplit) ?
        ((secondMode != ModeSplit) & (clockControl_q[SecondClockBit] | prescaleTick)) :
        (secondRun & (secondMode != ModeSplit) & (modeSelect_q[SecondCounterBit] ? secondPinEdge :
        (clockControl_q[SecondClockBit] | prescaleTick)));
    assign splitTick = (firstMode == ModeSplit) & secondRunBit &
        (clockControl_q[FirstClockBit] | prescaleTick);

    // register writes and counting; software write wins over count in same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeSelect_q <= ModeSelectReset;
            clockControl_q <= ClockControlReset;
            firstLow_q <= CountReset;
            firstHigh_q <= CountReset;
            secondLow_q <= CountReset;
            secondHigh_q <= CountReset;
        end else begin
            if (firstTick) begin
                {firstHigh_q, firstLow_q} <= step(firstMode, firstHigh_q, firstLow_q)[15:0];
            end
            if (splitTick) begin
                firstHigh_q <= firstHigh_q + 8'h01;
            end
            if (secondTick) begin
                {secondHigh_q, secondLow_q} <= step(secondMode, secondHigh_q, secondLow_q)[15:0];
            end
            if (sfrWrite) begin
                unique case (sfrAddr)
                    ModeSelectAddr: modeSelect_q <= sfrWdata;
                    ClockControlAddr: clockControl_q <= sfrWdata & ClockControlMask;
                    FirstLowAddr: firstLow_q <= sfrWdata;
                    FirstHighAddr: firstHigh_q <= sfrWdata;
                    SecondLowAddr: secondLow_q <= sfrWdata;
                    SecondHighAddr: secondHigh_q <= sfrWdata;
                    default: ;
                endcase
            end
        end
    end

    assign firstOvf = firstTick & step(firstMode, firstHigh_q, firstLow_q)[16];
    assign splitOvf = splitTick & (firstHigh_q == 8'hff);
    // second timer flag is stolen by the split high byte in split mode
    assign secondOvf = (firstMode == ModeSplit) ? splitOvf :
        (secondTick & step(secondMode, secondHigh_q, secondLow_q)[16]);

    // overflow flags: a new overflow wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            firstOverflowFlag <= 1'b0;
            secondOverflowFlag <= 1'b0;
        end else begin
            firstOverflowFlag <= firstOvf | (firstOverflowFlag & ~firstOverflowClear & ~firstVectorAck);
            secondOverflowFlag <= secondOvf | (secondOverflowFlag & ~secondOverflowClear & ~secondVectorAck);
        end
    end

    // registered read port, unmapped addresses read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfrRdata <= 8'h00;
        end else begin
            unique case (sfrAddr)
                ModeSelectAddr: sfrRdata <= modeSelect_q;
                ClockControlAddr: sfrRdata <= clockControl_q & ClockControlMask;
                FirstLowAddr: sfrRdata <= firstLow_q;
                FirstHighAddr: sfrRdata <= firstHigh_q;
                SecondLowAddr: sfrRdata <= secondLow_q;
                SecondHighAddr: sfrRdata <= secondHigh_q;
                default: sfrRdata <= 8'h00;
            endcase
        end
    end
endmodule

// >>> sim/legacy_timer_assertions.sv
`timescale 1ns/100ps
module legacy_timer_assertions
    import legacy_timer_pkg::*;
(
    // clock, reset and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    // timer control and flags
    input wire logic firstRunBit,
    input wire logic secondRunBit,
    input wire logic firstOverflowClear,
    input wire logic secondOverflowClear,
    input wire logic firstVectorAck,
    input wire logic secondVectorAck,
    input wire logic firstOverflowFlag,
    input wire logic secondOverflowFlag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a write, then a quiet cycle that reads the same place back
    sequence wr_hold(a);
        sfrWrite && sfrAddr == a ##1 !sfrWrite && sfrAddr == a;
    endsequence
    // read data lags the address by one edge, so the write shows two edges on
    a_mode_readback: assert property (wr_hold(ModeSelectAddr) |=> sfrRdata == $past(sfrWdata, 2))
        else $error("mode readback wrong");
    a_unused_zero: assert property ($past(sfrAddr) == ClockControlAddr |-> !(sfrRdata & ~ClockControlMask))
        else $error("unused bits not zero");
    a_first_sticky: assert property (firstOverflowFlag && !firstOverflowClear && !firstVectorAck |=> firstOverflowFlag)
        else $error("first flag dropped");
    a_second_sticky: assert property (secondOverflowFlag && !secondOverflowClear && !secondVectorAck |=> secondOverflowFlag)
        else $error("second flag dropped");
    // stopped for three edges first, so no overflow can still be in flight
    a_first_clear: assert property (!firstRunBit [*3] ##0 (firstOverflowClear || firstVectorAck) |=> !firstOverflowFlag)
        else $error("first flag not cleared");
    a_second_clear: assert property (!secondRunBit [*3] ##0 (secondOverflowClear || secondVectorAck) |=> !secondOverflowFlag)
        else $error("second flag not cleared");
    a_first_rise: assert property ($rose(firstOverflowFlag) |-> $past(firstRunBit) || $past(firstRunBit, 2))
        else $error("first flag without run");
    a_second_rise: assert property ($rose(secondOverflowFlag) |-> $past(secondRunBit) || $past(secondRunBit, 2))
        else $error("second flag without run");
endmodule

// >>> sim/dual_legacy_counter_timer_bench.sv
`timescale 1ns/100ps
module dual_legacy_counter_timer_bench;
    import legacy_timer_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, pin0 = 1'b1, pin1 = 1'b1, extClk = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
    logic [1:0] run = 2'b00, clr = 2'b00, ack = 2'b00, irq = 2'b11, flag;
    int bad_count = 0, checked = 0;
    // prescale 00, 01, 10 over a 48-cycle run
    logic [7:0] scaleExp [3] = '{8'h04, 8'h0c, 8'h01};
    // count pins idle high and the external clock idles low, so no false edge follows reset
    dual_legacy_counter_timer i_dual_legacy_counter_timer (.clk, .rst, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRdata,
        .firstRunBit(run[0]), .secondRunBit(run[1]), .firstOverflowClear(clr[0]), .secondOverflowClear(clr[1]),
        .firstVectorAck(ack[0]), .secondVectorAck(ack[1]), .firstOverflowFlag(flag[0]), .secondOverflowFlag(flag[1]),
        .firstExtIrqInput(irq[0]), .secondExtIrqInput(irq[1]), .firstCountPin(pin0), .secondCountPin(pin1),
        .extClock(extClk));
    // 100 ns period
    initial forever #50 clk = ~clk;
    task automatic chk(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask
    // read data is registered, so wait two edges before looking
    task automatic rd(input logic [7:0] a, exp, input string what);
        @(posedge clk);
        sfrAddr <= a;
        repeat (2) @(posedge clk);
        #1 chk(what, sfrRdata, exp);
    endtask
    // load, run for n edges, check both bytes and flags, then clear the flags
    task automatic run_case(input logic [7:0] mode, ck, lowA, lowV, highA, highV, input logic [1:0] which,
                            input int n, input logic [7:0] expLow, expHigh, input logic [1:0] expFlags);
        wr(ModeSelectAddr, mode);
        wr(ClockControlAddr, ck);
        wr(lowA, lowV);
        wr(highA, highV);
        @(posedge clk);
        run <= which;
        repeat (n) @(posedge clk);
        run <= 2'b00;
        rd(lowA, expLow, "count low");
        rd(highA, expHigh, "count high");
        chk("flags", {6'h00, flag}, {6'h00, expFlags});
        @(posedge clk);
        // the low mode bit picks software clear or vector ack, so both clear paths get used
        clr <= mode[0] ? 2'b00 : expFlags;
        ack <= mode[0] ? expFlags : 2'b00;
        @(posedge clk);
        clr <= 2'b00;
        ack <= 2'b00;
        #1 chk("flags cleared", {6'h00, flag}, 8'h00);
        $display("case mode %h clock %h done", mode, ck);
    endtask
    task automatic close_out;
        $display("%0d checks, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 8'h88; a <= 8'h8e; a++) rd(8'(a), 8'h00, "reset value");
        wr(ModeSelectAddr, 8'ha5);
        rd(ModeSelectAddr, 8'ha5, "mode");
        wr(ClockControlAddr, 8'hff);
        rd(ClockControlAddr, 8'h1b, "clock control");
        $display("register test done");
        run_case(8'h11, 8'h08, FirstLowAddr, 8'hfe, FirstHighAddr, 8'hff, 2'b01, 2, 8'h00, 8'h00, 2'b01);
        run_case(8'h20, 8'h10, SecondLowAddr, 8'hfe, SecondHighAddr, 8'h80, 2'b10, 3, 8'h81, 8'h80, 2'b10);
        run_case(8'h00, 8'h08, FirstLowAddr, 8'h1e, FirstHighAddr, 8'hff, 2'b01, 2, 8'h00, 8'h00, 2'b01);
        run_case(8'h03, 8'h08, FirstLowAddr, 8'h00, FirstHighAddr, 8'hff, 2'b10, 1, 8'h00, 8'h00, 2'b10);
        // second timer in its inactive mode must hold still even with the system clock selected
        run_case(8'h30, 8'h10, SecondLowAddr, 8'h00, SecondHighAddr, 8'h00, 2'b10, 10, 8'h00, 8'h00, 2'b00);
        irq <= 2'b00;
        run_case(8'h09, 8'h08, FirstLowAddr, 8'h00, FirstHighAddr, 8'h00, 2'b01, 10, 8'h00, 8'h00, 2'b00);
        run_case(8'h90, 8'h10, SecondLowAddr, 8'h00, SecondHighAddr, 8'h00, 2'b10, 10, 8'h00, 8'h00, 2'b00);
        irq <= 2'b11;
        run_case(8'h09, 8'h08, FirstLowAddr, 8'h00, FirstHighAddr, 8'h00, 2'b01, 10, 8'h0a, 8'h00, 2'b00);
        // counter function with the system clock selected: only pin falls may count
        wr(ModeSelectAddr, 8'h55);
        wr(ClockControlAddr, 8'h18);
        wr(FirstLowAddr, 8'h00);
        wr(SecondLowAddr, 8'h00);
        run <= 2'b11;
        repeat (6) begin
            repeat (4) @(posedge clk);
            pin0 <= ~pin0;
            pin1 <= ~pin1;
        end
        repeat (4) @(posedge clk);
        run <= 2'b00;
        rd(FirstLowAddr, 8'h03, "pin count");
        rd(SecondLowAddr, 8'h03, "second pin count");
        $display("pin test done");
        for (int k = 0; k < 3; k++) run_case(8'h01, 8'(k), FirstLowAddr, 8'h00, FirstHighAddr, 8'h00, 2'b01, 48, scaleExp[k], 8'h00, 2'b00);
        // external source: sixteen falls give two ticks whatever phase the prescaler starts in
        wr(ModeSelectAddr, 8'h01);
        wr(ClockControlAddr, 8'h03);
        wr(FirstLowAddr, 8'h00);
        run <= 2'b01;
        repeat (32) begin
            repeat (2) @(posedge clk);
            extClk <= ~extClk;
        end
        repeat (4) @(posedge clk);
        run <= 2'b00;
        rd(FirstLowAddr, 8'h02, "external prescale");
        $display("external prescale test done");
        close_out();
    end
endmodule
bind dual_legacy_counter_timer legacy_timer_assertions i_legacy_timer_assertions (.clk, .rst, .sfrAddr, .sfrWrite,
    .sfrWdata, .sfrRdata, .firstRunBit, .secondRunBit, .firstOverflowClear, .secondOverflowClear, .firstVectorAck,
    .secondVectorAck, .firstOverflowFlag, .secondOverflowFlag);
